// ==== design/stc_interp.sv ====
`timescale 1ns/10ps
`include "stc_regs.svh"
module stc_interp #(
	parameter int unsigned FILL_CYCLES  = `STC_CLK_HZ / 1000 * `STC_FILL_MS,
	parameter int unsigned BREAK_CYCLES = `STC_CLK_HZ / 1000 * `STC_BREAK_MS,
	parameter int unsigned BLINK_CYCLES = `STC_CLK_HZ / `STC_BLINK_HZ
) (
	// clock, reset, enable
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic           ce,
	// ahb-lite slave
	input  wire logic           hsel,
	input  wire logic [31:0]    haddr,
	input  wire logic [1:0]     htrans,
	input  wire logic           hwrite,
	input  wire logic [2:0]     hsize,
	input  wire logic [31:0]    hwdata,
	input  wire logic           hready,
	output logic                hreadyout,
	output logic                hresp,
	output logic [31:0]         hrdata,
	// received characters from the uart, same clock
	input  wire logic           rx_valid,
	input  wire logic [7:0]     rx_data,
	// raw receive line level, low is spacing
	input  wire logic           rx_line,
	// screen side
	output stc_pkg::stc_wr_s    scr_wr,
	output stc_pkg::stc_ctl_s   scr_ctl,
	output logic [4:0]          cursor_row,
	output logic [6:0]          cursor_col,
	output logic                video_invert,
	output logic                blink_visible,
	output logic                init_busy
);
	import stc_pkg::*;

	localparam int unsigned BLINK_ON = BLINK_CYCLES / 100 * `STC_BLINK_DUTY;
	localparam logic [4:0]  ROW_MAX  = 5'(`STC_ROWS - 1);
	localparam logic [6:0]  COL_MAX  = 7'(`STC_COLS - 1);
	localparam stc_cfg_s    CFG_RST  = stc_cfg_s'(`STC_CFG_RST);

	////////////////////////////////////////////////////////////////////////////
	// register file

	stc_cfg_s    cfg;
	logic        dp_write;
	logic [7:0]  dp_addr;
	logic        shift_attr;
	stc_esc_e    esc_state;
	logic [31:0] status_word;
	logic        addr_phase;

	// zero wait states while ce is high: read data is captured in the address phase
	assign hreadyout  = ce;
	assign hresp      = 1'b0;
	assign addr_phase = ce && hsel && hready && htrans[1];

	always_comb begin
		status_word                        = 32'h0;
		status_word[`STC_ST_ROW_LSB +: 5]  = cursor_row;
		status_word[`STC_ST_COL_LSB +: 7]  = cursor_col;
		status_word[`STC_ST_SHIFT]         = shift_attr;
		status_word[`STC_ST_BUSY]          = init_busy;
		status_word[`STC_ST_ESC]           = (esc_state != ESC_IDLE);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			hrdata   <= 32'h0;
		end else if (ce) begin
			dp_write <= addr_phase && hwrite;
			dp_addr  <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				case (haddr[7:0])
					`STC_CFG_OFS:    hrdata <= {22'h0, cfg};
					`STC_STATUS_OFS: hrdata <= status_word;
					default:         hrdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= CFG_RST;
		end else if (ce && dp_write && dp_addr == `STC_CFG_OFS) begin
			cfg <= stc_cfg_s'(hwdata[`STC_CFG_W-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration decode

	logic ff_init_en;
	logic break_init_en;
	logic no_parity;

	// straps a and b select the source, strap c is unused; strap b alone enables form feed,
	// strap a alone enables break
	assign ff_init_en    = cfg.remote_init_strap_b;
	assign break_init_en = cfg.remote_init_strap_a;
	assign no_parity     = (cfg.parity == 2'h0);

	// registered so the polarity output comes straight from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			video_invert <= !CFG_RST.video_polarity_strap;
		end else if (ce) begin
			video_invert <= !cfg.video_polarity_strap;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// break detection

	logic        line_meta;
	logic        line_sync;
	logic [31:0] space_cnt;
	logic        break_fire;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_meta <= 1'b1;
			line_sync <= 1'b1;
		end else if (ce) begin
			line_meta <= rx_line;
			line_sync <= line_meta;
		end
	end

	// fires once per spacing period; the line must go marking to re-arm
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			space_cnt <= 32'h0;
		end else if (ce) begin
			if (line_sync) begin
				space_cnt <= 32'h0;
			end else if (space_cnt <= BREAK_CYCLES) begin
				space_cnt <= space_cnt + 32'h1;
			end
		end
	end

	assign break_fire = break_init_en && (space_cnt == BREAK_CYCLES);

	////////////////////////////////////////////////////////////////////////////
	// character decode

	logic       take;
	logic [6:0] code;
	logic       is_ctrl;
	logic       ff_fire;
	logic       do_init;
	logic [31:0] fill_cnt;

	assign take    = ce && rx_valid && !init_busy;
	assign code    = rx_data[6:0];
	assign is_ctrl = (code < 7'h20) || (code == 7'h7f);
	assign ff_fire = take && esc_state == ESC_IDLE && code == `STC_FF && ff_init_en;
	assign do_init = ce && (ff_fire || break_fire);

	// characters arriving during the fill window are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fill_cnt  <= 32'h0;
			init_busy <= 1'b0;
		end else if (do_init) begin
			fill_cnt  <= 32'h0;
			init_busy <= 1'b1;
		end else if (ce && init_busy) begin
			fill_cnt  <= fill_cnt + 32'h1;
			init_busy <= (fill_cnt < FILL_CYCLES - 1);
		end
	end

	// out-of-range address bytes pin to the nearest edge rather than wrap
	function automatic logic [6:0] clamp_addr(input logic [6:0] b, input logic [6:0] lim);
		logic [6:0] v;
		v = (b < `STC_ADDR_BIAS) ? 7'h00 : 7'(b - `STC_ADDR_BIAS);
		return (v > lim) ? lim : v;
	endfunction

	logic [4:0] line_hold;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			esc_state <= ESC_IDLE;
			line_hold <= 5'h00;
		end else if (do_init) begin
			esc_state <= ESC_IDLE;
		end else if (take) begin
			case (esc_state)
				ESC_IDLE: begin
					if (code == `STC_ESC) begin
						esc_state <= ESC_GOT_ESC;
					end
				end
				// an unknown escape swallows its second byte
				ESC_GOT_ESC: begin
					esc_state <= (code == `STC_Y) ? ESC_WANT_LINE : ESC_IDLE;
				end
				ESC_WANT_LINE: begin
					line_hold <= 5'(clamp_addr(code, {2'h0, ROW_MAX}));
					esc_state <= ESC_WANT_COL;
				end
				ESC_WANT_COL: begin
					esc_state <= ESC_IDLE;
				end
				default: begin
					esc_state <= ESC_IDLE;
				end
			endcase
		end
	end

	// shift state only counts when attributes come from shift codes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_attr <= 1'b0;
		end else if (do_init) begin
			shift_attr <= 1'b0;
		end else if (take && esc_state == ESC_IDLE) begin
			if (code == `STC_SO) begin
				shift_attr <= 1'b1;
			end else if (code == `STC_SI) begin
				shift_attr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cursor and screen commands

	logic attr_on;

	assign attr_on = cfg.attribute_source_post ? shift_attr
	                                           : (no_parity && rx_data[7]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cursor_row <= 5'h00;
			cursor_col <= 7'h00;
			scr_wr     <= '0;
			scr_ctl    <= '0;
		end else if (ce) begin
			scr_wr.valid       <= 1'b0;
			scr_ctl.scroll     <= 1'b0;
			scr_ctl.clear_line <= 1'b0;
			scr_ctl.init       <= 1'b0;
			if (do_init) begin
				cursor_row   <= 5'h00;
				cursor_col   <= 7'h00;
				scr_ctl.init <= 1'b1;
			end else if (take && esc_state == ESC_WANT_COL) begin
				cursor_row <= line_hold;
				cursor_col <= clamp_addr(code, COL_MAX);
			end else if (take && esc_state == ESC_IDLE && is_ctrl) begin
				case (code)
					`STC_BS: begin
						if (cursor_col != 7'h00) begin
							cursor_col <= cursor_col - 7'h1;
						end
					end
					`STC_HT: begin
						if (cursor_col != COL_MAX) begin
							cursor_col <= cursor_col + 7'h1;
						end
					end
					`STC_CR: begin
						cursor_col <= 7'h00;
					end
					`STC_LF, `STC_VT: begin
						if (cursor_row != ROW_MAX) begin
							cursor_row <= cursor_row + 5'h1;
						end else begin
							scr_ctl.scroll     <= 1'b1;
							scr_ctl.clear_line <= (code == `STC_LF);
						end
					end
					default: begin
					end
				endcase
			end else if (take && esc_state == ESC_IDLE) begin
				// printable: draw then advance, holding at the right margin
				scr_wr.valid   <= 1'b1;
				scr_wr.code    <= code;
				scr_wr.row     <= cursor_row;
				scr_wr.col     <= cursor_col;
				scr_wr.reverse <= attr_on && !cfg.attribute_type_post;
				scr_wr.blink   <= attr_on && cfg.attribute_type_post;
				scr_wr.half    <= attr_on && !cfg.half_int_off;
				scr_wr.alt     <= attr_on && !cfg.alt_charset_strap;
				if (cursor_col != COL_MAX) begin
					cursor_col <= cursor_col + 7'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// blink timebase

	logic [31:0] blink_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_cnt     <= 32'h0;
			blink_visible <= 1'b1;
		end else if (ce) begin
			blink_cnt     <= (blink_cnt >= BLINK_CYCLES - 1) ? 32'h0 : blink_cnt + 32'h1;
			blink_visible <= (blink_cnt < BLINK_ON);
		end
	end

endmodule

// ==== design/stc_regs.svh ====
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// register byte offsets
`define STC_CFG_OFS      8'h00
`define STC_STATUS_OFS   8'h04

// configuration word: width and value after reset (factory setup)
`define STC_CFG_W        10
`define STC_CFG_RST      10'h0da

// status word field positions
`define STC_ST_ROW_LSB   0
`define STC_ST_COL_LSB   8
`define STC_ST_SHIFT     16
`define STC_ST_BUSY      17
`define STC_ST_ESC       18

// screen geometry and cursor address offsets
`define STC_ROWS         25
`define STC_COLS         80
`define STC_ADDR_BIAS    7'h20

// control codes and the cursor address escape letter
`define STC_BS           7'h08
`define STC_HT           7'h09
`define STC_LF           7'h0a
`define STC_VT           7'h0b
`define STC_FF           7'h0c
`define STC_CR           7'h0d
`define STC_SO           7'h0e
`define STC_SI           7'h0f
`define STC_ESC          7'h1b
`define STC_Y            7'h59

// timing
`define STC_CLK_HZ       125000000
`define STC_FILL_MS      34
`define STC_BREAK_MS     10
`define STC_BLINK_HZ     2
`define STC_BLINK_DUTY   70

`endif

// ==== design/stc_pkg.sv ====
package stc_pkg;

	typedef enum logic [1:0] {
		ESC_IDLE,
		ESC_GOT_ESC,
		ESC_WANT_LINE,
		ESC_WANT_COL
	} stc_esc_e;

	typedef struct packed {
		logic [1:0] parity;
		logic       attribute_type_post;
		logic       attribute_source_post;
		logic       half_int_off;
		logic       alt_charset_strap;
		logic       video_polarity_strap;
		logic       remote_init_strap_a;
		logic       remote_init_strap_b;
		logic       remote_init_strap_c;
	} stc_cfg_s;

	typedef struct packed {
		logic       valid;
		logic [6:0] code;
		logic [4:0] row;
		logic [6:0] col;
		logic       reverse;
		logic       blink;
		logic       half;
		logic       alt;
	} stc_wr_s;

	typedef struct packed {
		logic scroll;
		logic clear_line;
		logic init;
	} stc_ctl_s;

endpackage

// ==== testbench/stc_interp_assertions.sv ====
`timescale 1ns/10ps
module stc_interp_assertions (
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// watched ports
	input wire logic              rx_valid,
	input wire stc_pkg::stc_wr_s  scr_wr,
	input wire stc_pkg::stc_ctl_s scr_ctl,
	input wire logic [4:0]        cursor_row,
	input wire logic [6:0]        cursor_col,
	input wire logic              init_busy
);
	import stc_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ctrl_not_drawn;
		scr_wr.valid |-> scr_wr.code >= 7'h20 && scr_wr.code != 7'h7f;
	endproperty
	a_ctrl_not_drawn: assert property (p_ctrl_not_drawn)
		else $error("control code drawn");
	property p_draw_at_cursor;
		scr_wr.valid |-> $past(rx_valid) && scr_wr.col == $past(cursor_col)
			&& scr_wr.row == $past(cursor_row);
	endproperty
	a_draw_at_cursor: assert property (p_draw_at_cursor)
		else $error("glyph not at cursor");
	property p_cursor_bounds;
		cursor_row <= 5'd24 && cursor_col <= 7'd79;
	endproperty
	a_cursor_bounds: assert property (p_cursor_bounds)
		else $error("cursor off screen");
	property p_scroll_last_row;
		scr_ctl.scroll |-> cursor_row == 5'd24 && !scr_wr.valid;
	endproperty
	a_scroll_last_row: assert property (p_scroll_last_row)
		else $error("scroll away from last row");
	property p_clear_needs_scroll;
		scr_ctl.clear_line |-> scr_ctl.scroll;
	endproperty
	a_clear_needs_scroll: assert property (p_clear_needs_scroll)
		else $error("clear without scroll");
	property p_init_home;
		scr_ctl.init |-> cursor_row == 5'd0 && cursor_col == 7'd0 && init_busy;
	endproperty
	a_init_home: assert property (p_init_home)
		else $error("init left cursor or busy wrong");
	// exact for the shortened fill count of 20 used in simulation
	property p_fill_window;
		$rose(init_busy) |-> init_busy[*8] ##1 init_busy[*8] ##1 init_busy[*4] ##1 !init_busy;
	endproperty
	a_fill_window: assert property (p_fill_window)
		else $error("fill window length wrong");
	property p_busy_drops;
		init_busy && rx_valid |=> !scr_wr.valid && !scr_ctl.scroll && $stable(cursor_col);
	endproperty
	a_busy_drops: assert property (p_busy_drops)
		else $error("char taken while busy");
endmodule

bind stc_interp stc_interp_assertions u_stc_interp_assertions (
	.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid), .scr_wr(scr_wr),
	.scr_ctl(scr_ctl), .cursor_row(cursor_row), .cursor_col(cursor_col),
	.init_busy(init_busy)
);

// ==== testbench/stc_host_model.sv ====
`timescale 1ns/10ps
module stc_host #(
	parameter int SCROLL_GAP = 4
) (
	// serial side of the interpreter
	input  wire logic  hclk,
	output logic       rx_valid,
	output logic [7:0] rx_data,
	output logic       rx_line
);
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		rx_line  = 1'b1;
	end
	task automatic send(input logic [7:0] c);
		if (c[6:0] == 7'h0a || c[6:0] == 7'h0b) begin
			repeat (SCROLL_GAP) @(posedge hclk);
		end
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_data  <= c;
		@(posedge hclk);
		rx_valid <= 1'b0;
		// stale byte shows inverted so it is never read as fresh
		rx_data  <= ~c;
	endtask
	task automatic brk(input int n);
		@(posedge hclk);
		rx_line <= 1'b0;
		repeat (n) @(posedge hclk);
		rx_line <= 1'b1;
	endtask
	task automatic cup(input logic [4:0] r, input logic [6:0] c);
		send(8'h1b);
		send(8'h59);
		send(8'h20 + {3'h0, r});
		send(8'h20 + {1'h0, c});
	endtask
endmodule

// ==== testbench/stc_interp_tb.sv ====
`timescale 1ns/10ps
module stc_interp_tb;
	import stc_pkg::*;
	localparam int FILL = 20;
	logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
	logic        rx_valid, rx_line, video_invert, blink_visible, init_busy;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0]  rx_data;
	logic [4:0]  cursor_row;
	logic [6:0]  cursor_col;
	stc_wr_s     scr_wr;
	stc_ctl_s    scr_ctl;
	int          mismatches, n_checks, n_init, n_base, n;
	stc_interp #(.FILL_CYCLES(FILL), .BREAK_CYCLES(16), .BLINK_CYCLES(100)) u_stc_interp (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_line(rx_line), .scr_wr(scr_wr),
		.scr_ctl(scr_ctl), .cursor_row(cursor_row), .cursor_col(cursor_col),
		.video_invert(video_invert), .blink_visible(blink_visible), .init_busy(init_busy));
	stc_host u_stc_host (.hclk(hclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_line(rx_line));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) if (scr_ctl.init === 1'b1) n_init++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		hsize  <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic ch(input logic [7:0] c, input logic [31:0] e, input string m);
		u_stc_host.send(c);
		#1;
		chk(scr_wr, e, m);
	endtask
	task automatic ctl(input logic [7:0] c, input logic [4:0] r, input logic [6:0] k);
		u_stc_host.send(c);
		#1;
		chk({scr_wr.valid, cursor_row, cursor_col}, {1'b0, r, k}, "control");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		stop_test();
	end
	initial begin
		{hresetn, hwrite, htrans, haddr, hwdata} = '0;
		{ce, hsel, hsize} = 5'h18;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 32'h0, 32'h0);
		chk(q, 32'h0da, "cfg reset");
		bus(1, 32'h4, 32'hffff);
		bus(0, 32'h4, 32'h0);
		chk(q, 32'h0, "status read only");
		bus(1, 32'h8, 32'h5);
		bus(0, 32'h8, 32'h0);
		chk(q, 32'h0, "unmapped");
		chk(video_invert, 1'b0, "forward video");
		bus(1, 32'h0, 32'h16);
		bus(0, 32'h0, 32'h0);
		chk(q, 32'h16, "cfg readback");
		chk(video_invert, 1'b1, "reverse screen");
		hsel <= 1'b0;
		bus(1, 32'h0, 32'h3ff);
		hsel <= 1'b1;
		bus(0, 32'h0, 32'h0);
		chk(q, 32'h16, "deselected write ignored");
		chk(hresp, 1'b0, "okay response");
		n = 0;
		repeat (100) begin
			@(posedge hclk);
			if (blink_visible === 1'b1) n++;
		end
		chk(n, 70, "blink duty");
		$display("test registers done");
		ch(8'hc1, {1'b1, 7'h41, 5'd0, 7'd0, 4'b1010}, "bit 8 reverse");
		bus(1, 32'h0, 32'h86);
		ch(8'hc2, {1'b1, 7'h42, 5'd0, 7'd1, 4'b0111}, "blink alt set");
		ch(8'h43, {1'b1, 7'h43, 5'd0, 7'd2, 4'b0000}, "plain");
		ctl(8'h08, 5'd0, 7'd2);
		ctl(8'h0d, 5'd0, 7'd0);
		ctl(8'h08, 5'd0, 7'd0);
		ctl(8'h09, 5'd0, 7'd1);
		@(posedge hclk);
		ce <= 1'b0;
		u_stc_host.send(8'h42);
		#1;
		chk({hreadyout, scr_wr.valid, cursor_row, cursor_col}, 14'h0001, "frozen by enable");
		@(posedge hclk);
		ce <= 1'b1;
		u_stc_host.cup(5'd0, 7'd79);
		ctl(8'h09, 5'd0, 7'd79);
		u_stc_host.cup(5'd9, 7'd33);
		ctl(8'h0a, 5'd10, 7'd33);
		u_stc_host.cup(5'd24, 7'd79);
		ctl(8'h0a, 5'd24, 7'd79);
		chk(scr_ctl, 3'b110, "scroll and clear");
		ctl(8'h0b, 5'd24, 7'd79);
		chk(scr_ctl, 3'b100, "scroll keeps line");
		$display("test cursor done");
		for (int p = 1; p < 3; p++) begin
			bus(1, 32'h0, {22'h0, p[1:0], 8'h56});
			u_stc_host.cup(p[4:0], 7'd0);
			u_stc_host.send(8'h0e);
			bus(0, 32'h4, 32'h0);
			chk(q, {15'h0, 1'b1, 1'b0, 7'd0, 3'h0, p[4:0]}, "status shift");
			ch(8'h41, {1'b1, 7'h41, p[4:0], 7'd0, 4'b1010}, "after shift out");
			u_stc_host.send(8'h0f);
			ch(8'hc1, {1'b1, 7'h41, p[4:0], 7'd1, 4'b0000}, "after shift in");
		end
		bus(1, 32'h0, 32'h116);
		ch(8'hc1, {1'b1, 7'h41, 5'd2, 7'd2, 4'b0000}, "parity ignores bit 8");
		$display("test shift done");
		for (int i = 0; i < 4; i++) begin
			bus(1, 32'h0, {29'h2, i[1], i[0], 1'b0});
			n_base = n_init;
			u_stc_host.send(8'h0c);
			repeat (FILL + 4) @(posedge hclk);
			chk(n_init - n_base, {31'h0, i[0]}, "form feed init");
			u_stc_host.brk(24);
			repeat (FILL + 4) @(posedge hclk);
			chk(n_init - n_base, 32'(i[0]) + 32'(i[1]), "break init");
		end
		u_stc_host.send(8'h0c);
		repeat (FILL + 4) @(posedge hclk);
		u_stc_host.cup(5'd3, 7'd4);
		u_stc_host.send(8'h1b);
		u_stc_host.send(8'h59);
		bus(0, 32'h4, 32'h0);
		chk(q, 32'h40403, "escape pending");
		u_stc_host.brk(24);
		repeat (4) @(posedge hclk);
		chk({init_busy, cursor_row, cursor_col}, 13'h1000, "break homes");
		bus(0, 32'h4, 32'h0);
		chk(q, 32'h20000, "status busy");
		u_stc_host.send(8'h45);
		#1;
		chk({init_busy, scr_wr.valid, cursor_row, cursor_col}, 14'h2000, "dropped while busy");
		repeat (FILL + 4) @(posedge hclk);
		ch(8'h41, {1'b1, 7'h41, 5'd0, 7'd0, 4'b0000}, "escape aborted");
		$display("test init done");
		stop_test();
	end
endmodule
